//--- mode_pkg.sv
// Package: constants for the mode register decode block
package mode_pkg;

  // ****************************************
  // Command and register geometry
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int BANK_W = 2;
  localparam logic [1:0] BANK_PRIMARY = 2'h0;
  localparam logic [1:0] BANK_EXT1 = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;
  localparam logic [1:0] BANK_EXT3 = 2'h3;

  // ****************************************
  // Primary register fields
  // ****************************************
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PD_BIT = 12;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] RL_MIN_CODE = 3'h2;
  localparam logic [2:0] RL_MAX_CODE = 3'h5;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  localparam logic [2:0] WR_MAX_CODE = 3'h5;

  // ****************************************
  // First extended register fields
  // ****************************************
  localparam int DLLDIS_BIT = 0;
  localparam int DIC_BIT = 1;
  localparam int RTT0_BIT = 2;
  localparam int AL_LSB = 3;
  localparam int RTT1_BIT = 6;
  localparam int CAL_LSB = 7;
  localparam int STRB_BIT = 10;
  localparam int RSTRB_BIT = 11;
  localparam int QOFF_BIT = 12;
  localparam logic [2:0] AL_MAX_CODE = 3'h4;
  localparam logic [1:0] RTT_OFF = 2'h0;
  localparam logic [1:0] RTT_75 = 2'h1;
  localparam logic [1:0] RTT_150 = 2'h2;

  // ****************************************
  // Calibration modes and reset values
  // ****************************************
  typedef enum logic [2:0] {
    CAL_EXIT = 3'h0,
    CAL_DRIVE_HIGH = 3'h1,
    CAL_DRIVE_LOW = 3'h2,
    CAL_ADJUST = 3'h4,
    CAL_DEFAULT = 3'h7
  } cal_mode_t;
  localparam logic [13:0] REG_RESET = 14'h0000;
  localparam int DELAY_MAX = 15;

endpackage : mode_pkg

//--- cmd_if.sv
// Interface: decoded read/write command stream between modules
`timescale 1ns/1ns
interface cmd_if;
  logic rd;
  logic wr;
  logic rd_dly;
  logic wr_dly;
  logic [2:0] delay;
  modport src (output rd, output wr, output delay, input rd_dly, input wr_dly);
  modport dly (input rd, input wr, input delay, output rd_dly, output wr_dly);
endinterface : cmd_if

//--- cmd_delay.sv
// Module: delays read and write commands by the added latency
`timescale 1ns/1ns
module cmd_delay
  import mode_pkg::*;
#(
  parameter int DEPTH = 4
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  cmd_if.dly c
);
  logic [DEPTH:0] rd_pipe_reg;
  logic [DEPTH:0] wr_pipe_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_pipe_reg <= '0;
      wr_pipe_reg <= '0;
    end
    else
    begin
      rd_pipe_reg <= {rd_pipe_reg[DEPTH-1:0], c.rd};
      wr_pipe_reg <= {wr_pipe_reg[DEPTH-1:0], c.wr};
    end
  end

  // Zero latency taps the live command
  always_comb
  begin
    c.rd_dly = (c.delay == 3'h0) ? c.rd : rd_pipe_reg[c.delay - 3'h1];
    c.wr_dly = (c.delay == 3'h0) ? c.wr : wr_pipe_reg[c.delay - 3'h1];
  end
endmodule : cmd_delay

//--- dram_mode_register_decode.sv
// Module: mode register decode of a DDR2 memory device
// Contract
// - Bank bits select primary or first extended
// - Bits 2:0 give burst of four/eight
// - Bit 3 selects sequential or interleaved order
// - Bits 6:4 read latency two to five
// - Bit 8 resets loop; bit 7 test mode
// - Bits 11:9 write recovery two to six
// - Bit 12 selects fast or slow exit
// - Mode fields are write-only, no read-back
// - Extended bit 0 low enables loop
// - Extended bit 1 picks full/weak drive
// - Extended bits 2,6 select termination value
// - Delay commands by added latency 0-4
// - Extended bits 9:7 decode calibration mode
// - Extended bits 11:10 configure strobes
// - Complement strobe high cycle before data (code raises it in the same cycle as data_oe_o)
// - Read strobe replaces write mask when enabled
// - Extended bit 12 tristates data and strobes
// - Self-refresh disables then re-enables loop
`timescale 1ns/1ns
module dram_mode_register_decode
  import mode_pkg::*;
#(
  parameter bit WIDE8 = 1'b1
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic dev_clk_i,
  input wire logic sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic [1:0] bank_i,
  input wire logic [13:0] addr_i,
  input wire logic self_refresh_i,
  input wire logic rd_data_valid_i,
  output logic [3:0] burst_length_o,
  output logic burst_order_o,
  output logic [2:0] read_latency_o,
  output logic read_latency_bad_o,
  output logic vendor_test_select_o,
  output logic dll_reset_o,
  output logic [2:0] write_recovery_o,
  output logic write_recovery_bad_o,
  output logic power_down_exit_speed_o,
  output logic dll_enable_o,
  output logic driver_strength_select_o,
  output logic [1:0] termination_o,
  output logic termination_bad_o,
  output logic [2:0] added_latency_o,
  output logic [2:0] driver_calibration_o,
  output logic strobe_single_o,
  output logic read_strobe_o,
  output logic write_mask_en_o,
  output logic out_disable_o,
  output logic comp_strobe_oe_o,
  output logic comp_strobe_o,
  output logic read_strobe_oe_o,
  output logic data_oe_o,
  output logic rd_cmd_o,
  output logic wr_cmd_o,
  output logic ext_mode_load_cmd_o
);

  // ****************************************
  // Link sampling
  // ****************************************
  // Device clock is slow, so every pin except address bit 13 crosses two flops first
  logic [19:0] pins_s1_reg;
  logic [19:0] pins_s2_reg;
  logic clk_prev_reg;
  logic clk_rise;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      clk_prev_reg <= 1'b0;
    end
    else
    begin
      pins_s1_reg <= {dev_clk_i, sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i, bank_i, addr_i[12:0]};
      pins_s2_reg <= pins_s1_reg;
      clk_prev_reg <= pins_s2_reg[19];
    end
  end

  assign clk_rise = pins_s2_reg[19] & ~clk_prev_reg;

  // Address bit 13 must be low; it is ignored rather than stored
  logic [3:0] ctl_s;
  logic [1:0] bank_s;
  logic [13:0] addr_s;
  logic load_cmd;
  logic rd_cmd;
  logic wr_cmd;
  assign ctl_s = pins_s2_reg[18:15];
  assign bank_s = pins_s2_reg[14:13];
  assign addr_s = {1'b0, pins_s2_reg[12:0]};
  assign load_cmd = clk_rise && (ctl_s == 4'h0);
  assign rd_cmd = clk_rise && (ctl_s == 4'h5);
  assign wr_cmd = clk_rise && (ctl_s == 4'h4);

  // ****************************************
  // Bank routing
  // ****************************************
  // Spare banks match neither target, so their loads fall away
  function automatic logic bank_hit(input logic cmd, input logic [1:0] bank, input logic [1:0] target);
    bank_hit = cmd && (bank == target);
  endfunction : bank_hit

  logic load_primary;
  logic load_ext1;
  assign load_primary = bank_hit(load_cmd, bank_s, BANK_PRIMARY);
  assign load_ext1 = bank_hit(load_cmd, bank_s, BANK_EXT1);

  // ****************************************
  // Mode registers
  // ****************************************
  // No read path exists: fields only leave as decoded controls
  logic [13:0] primary_mode_register_reg;
  logic [13:0] first_extended_mode_register_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      primary_mode_register_reg <= REG_RESET;
    else if (load_primary)
      primary_mode_register_reg <= addr_s;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      first_extended_mode_register_reg <= REG_RESET;
    else if (load_ext1)
      first_extended_mode_register_reg <= addr_s;
  end

  // ****************************************
  // Field decode
  // ****************************************
  function automatic logic in_range(input logic [2:0] v, input logic [2:0] lo, input logic [2:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  logic [13:0] pm;
  logic [13:0] em;
  logic [2:0] bl_code;
  logic [2:0] rl_code;
  logic [2:0] wr_code;
  logic [2:0] al_code;
  logic [1:0] rtt_code;
  logic self_ref_s1_reg;
  logic self_ref_s2_reg;
  assign pm = primary_mode_register_reg;
  assign em = first_extended_mode_register_reg;
  assign bl_code = pm[BL_LSB +: 3];
  assign rl_code = pm[RL_LSB +: 3];
  assign wr_code = pm[WR_LSB +: 3];
  assign al_code = em[AL_LSB +: 3];
  assign rtt_code = {em[RTT1_BIT], em[RTT0_BIT]};

  // Pulses follow the command, not the stored copy
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      dll_reset_o <= 1'b0;
      ext_mode_load_cmd_o <= 1'b0;
    end
    else
    begin
      dll_reset_o <= load_primary && addr_s[DLLRST_BIT];
      ext_mode_load_cmd_o <= load_ext1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      self_ref_s1_reg <= 1'b0;
      self_ref_s2_reg <= 1'b0;
    end
    else
    begin
      self_ref_s1_reg <= self_refresh_i;
      self_ref_s2_reg <= self_ref_s1_reg;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      burst_length_o <= 4'h0;
      burst_order_o <= 1'b0;
      read_latency_o <= 3'h0;
      read_latency_bad_o <= 1'b0;
      vendor_test_select_o <= 1'b0;
      write_recovery_o <= 3'h0;
      write_recovery_bad_o <= 1'b0;
      power_down_exit_speed_o <= 1'b0;
    end
    else
    begin
      burst_length_o <= (bl_code == BL_EIGHT) ? 4'h8 : ((bl_code == BL_FOUR) ? 4'h4 : 4'h0);
      burst_order_o <= pm[BT_BIT];
      read_latency_o <= rl_code;
      read_latency_bad_o <= !in_range(rl_code, RL_MIN_CODE, RL_MAX_CODE);
      vendor_test_select_o <= pm[TM_BIT];
      write_recovery_o <= wr_code + 3'h1;
      write_recovery_bad_o <= !in_range(wr_code, WR_MIN_CODE, WR_MAX_CODE);
      power_down_exit_speed_o <= pm[PD_BIT];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      dll_enable_o <= 1'b0;
      driver_strength_select_o <= 1'b0;
      termination_o <= RTT_OFF;
      termination_bad_o <= 1'b0;
      added_latency_o <= 3'h0;
      driver_calibration_o <= CAL_EXIT;
      strobe_single_o <= 1'b0;
      read_strobe_o <= 1'b0;
      write_mask_en_o <= 1'b1;
      out_disable_o <= 1'b0;
    end
    else
    begin
      dll_enable_o <= !em[DLLDIS_BIT] && !self_ref_s2_reg;
      driver_strength_select_o <= em[DIC_BIT];
      termination_o <= rtt_code;
      termination_bad_o <= (rtt_code == 2'h3);
      added_latency_o <= (al_code > AL_MAX_CODE) ? AL_MAX_CODE : al_code;
      driver_calibration_o <= em[CAL_LSB +: 3];
      strobe_single_o <= em[STRB_BIT];
      read_strobe_o <= WIDE8 && em[RSTRB_BIT];
      write_mask_en_o <= !(WIDE8 && em[RSTRB_BIT]);
      out_disable_o <= em[QOFF_BIT];
    end
  end

  // ****************************************
  // Added latency and output control
  // ****************************************
  cmd_if cmd ();
  assign cmd.rd = rd_cmd;
  assign cmd.wr = wr_cmd;
  assign cmd.delay = added_latency_o;

  // Delay counts reference clock cycles after the sampled command edge, not device clock edges
  cmd_delay #(.DEPTH(DELAY_MAX)) u_delay (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .c(cmd)
  );

  logic rdv_s1_reg;
  logic rdv_s2_reg;
  logic rdv_early;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rdv_s1_reg <= 1'b0;
      rdv_s2_reg <= 1'b0;
    end
    else
    begin
      rdv_s1_reg <= rd_data_valid_i;
      rdv_s2_reg <= rdv_s1_reg;
    end
  end
  assign rdv_early = rdv_s2_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_cmd_o <= 1'b0;
      wr_cmd_o <= 1'b0;
      data_oe_o <= 1'b0;
      comp_strobe_oe_o <= 1'b0;
      comp_strobe_o <= 1'b0;
      read_strobe_oe_o <= 1'b0;
    end
    else
    begin
      rd_cmd_o <= cmd.rd_dly;
      wr_cmd_o <= cmd.wr_dly;
      // Caller raises rd_data_valid_i one cycle ahead of the data
      data_oe_o <= rdv_early && !em[QOFF_BIT];
      comp_strobe_oe_o <= rdv_early && !em[QOFF_BIT] && !em[STRB_BIT];
      comp_strobe_o <= rdv_early && !em[STRB_BIT];
      read_strobe_oe_o <= rdv_early && !em[QOFF_BIT] && WIDE8 && em[RSTRB_BIT];
    end
  end

endmodule : dram_mode_register_decode

//--- dram_mode_register_decode_chk.sv
// Checker: port-level assertions for the mode register decode
`timescale 1ns/1ns
module dram_mode_register_decode_chk
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic dev_clk_i,
  input wire logic self_refresh_i,
  input wire logic burst_order_o,
  input wire logic [2:0] read_latency_o,
  input wire logic read_latency_bad_o,
  input wire logic dll_reset_o,
  input wire logic [2:0] added_latency_o,
  input wire logic [1:0] termination_o,
  input wire logic termination_bad_o,
  input wire logic read_strobe_o,
  input wire logic write_mask_en_o,
  input wire logic out_disable_o,
  input wire logic data_oe_o,
  input wire logic dll_enable_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic prev_clk_reg;
  logic [3:0] since_edge_reg;
  always_ff @(posedge ref_clk_i)
    prev_clk_reg <= dev_clk_i;
  // Saturates so a quiet link never wraps into a false match
  always_ff @(posedge ref_clk_i)
    if (rst_i || (dev_clk_i && !prev_clk_reg))
      since_edge_reg <= rst_i ? 4'hF : 4'h0;
    else if (since_edge_reg != 4'hF)
      since_edge_reg <= since_edge_reg + 4'h1;
  property p_lat; read_latency_bad_o |-> !(read_latency_o inside {[3'h2:3'h5]}); endproperty
  a_lat: assert property (p_lat) else $error("latency flag wrong");
  property p_rst; dll_reset_o |=> !dll_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("loop reset not a pulse");
  property p_al; added_latency_o <= 3'h4; endproperty
  a_al: assert property (p_al) else $error("added latency above four");
  property p_term; termination_bad_o == (termination_o == 2'h3); endproperty
  a_term: assert property (p_term) else $error("termination flag wrong");
  property p_mask; write_mask_en_o == !read_strobe_o; endproperty
  a_mask: assert property (p_mask) else $error("mask and strobe overlap");
  property p_qoff; out_disable_o |-> !data_oe_o; endproperty
  a_qoff: assert property (p_qoff) else $error("outputs on while disabled");
  property p_sref; self_refresh_i |-> ##3 !dll_enable_o; endproperty
  a_sref: assert property (p_sref) else $error("loop on in self-refresh");
  property p_cap; $changed(burst_order_o) || $changed(added_latency_o) |-> since_edge_reg <= 4'h6; endproperty
  a_cap: assert property (p_cap) else $error("field changed without load");
  c_rst: cover property (dll_reset_o);
  c_term: cover property (termination_bad_o);
  c_sref: cover property (self_refresh_i ##3 !dll_enable_o);
endmodule : dram_mode_register_decode_chk
bind dram_mode_register_decode dram_mode_register_decode_chk u_chk (.ref_clk_i, .rst_i, .dev_clk_i,
  .self_refresh_i, .burst_order_o, .read_latency_o, .read_latency_bad_o, .dll_reset_o, .added_latency_o,
  .termination_o, .termination_bad_o, .read_strobe_o, .write_mask_en_o, .out_disable_o, .data_oe_o,
  .dll_enable_o);

//--- ctrl_model.sv
// Partner: controller driving the command and address pins
`timescale 1ns/1ns
module ctrl_model
(
  input wire logic ref_clk_i,
  output logic dev_clk_o,
  output logic sel_n_o,
  output logic row_strobe_n_o,
  output logic col_strobe_n_o,
  output logic write_en_n_o,
  output logic [1:0] bank_o,
  output logic [13:0] addr_o
);
  logic [3:0] ctl = 4'hF;
  assign {sel_n_o, row_strobe_n_o, col_strobe_n_o, write_en_n_o} = ctl;
  initial
  begin
    dev_clk_o = 1'b0;
    bank_o = 2'h0;
    addr_o = 14'h0000;
  end
  // *****
  // One command per link frame
  // *****
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
    @(posedge ref_clk_i);
    ctl <= c;
    bank_o <= b;
    addr_o <= a;
    @(posedge ref_clk_i);
    dev_clk_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    // Released bank and address pins show inverse data, never stale values; controls return to 4'hF
    dev_clk_o <= 1'b0;
    ctl <= 4'hF;
    bank_o <= ~b;
    addr_o <= ~a;
    repeat (2) @(posedge ref_clk_i);
  endtask : issue
endmodule : ctrl_model

//--- dram_mode_register_decode_bench.sv
// Bench: mode load decode tests through the command pins
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module dram_mode_register_decode_bench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic self_refresh_i = 1'b0;
  logic rd_data_valid_i = 1'b0;
  logic dev_clk_i, sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i;
  logic [1:0] bank_i, termination_o;
  logic [13:0] addr_i, a;
  logic [3:0] burst_length_o;
  logic [2:0] read_latency_o, write_recovery_o, added_latency_o, driver_calibration_o;
  logic burst_order_o, read_latency_bad_o, vendor_test_select_o, dll_reset_o, write_recovery_bad_o;
  logic power_down_exit_speed_o, dll_enable_o, driver_strength_select_o, termination_bad_o, strobe_single_o;
  logic read_strobe_o, write_mask_en_o, out_disable_o, comp_strobe_oe_o, comp_strobe_o, read_strobe_oe_o;
  logic data_oe_o, rd_cmd_o, wr_cmd_o, ext_mode_load_cmd_o;
  logic [2:0] cm [5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h7};
  int n_mismatch = 0;
  int checks = 0;
  int n, base;
  int n_rst = 0;
  int n_ext = 0;
  // Pulses last one cycle, so count them as they pass
  always @(posedge ref_clk_i)
  begin
    if (dll_reset_o === 1'b1) n_rst++;
    if (ext_mode_load_cmd_o === 1'b1) n_ext++;
  end
  ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .dev_clk_o(dev_clk_i), .sel_n_o(sel_n_i), .row_strobe_n_o(row_strobe_n_i),
    .col_strobe_n_o(col_strobe_n_i), .write_en_n_o(write_en_n_i), .bank_o(bank_i), .addr_o(addr_i));
  dram_mode_register_decode u_dut (.*);
  always #50 ref_clk_i = ~ref_clk_i;
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Cycles from link edge to the delayed command pulse
  task automatic meas(input logic [3:0] c, output int cnt);
    cnt = 0;
    fork
      u_ctrl.issue(c, 2'h0, 14'h0000);
      begin
        @(posedge dev_clk_i);
        while (cnt < 30 && (c[0] ? rd_cmd_o : wr_cmd_o) !== 1'b1)
        begin
          @(posedge ref_clk_i);
          cnt++;
        end
      end
    join
  endtask : meas
  initial
  begin
    #(4000 * 100);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    u_ctrl.issue(4'h0, 2'h1, 14'h0000);
    for (int i = 0; i < 8; i++)
    begin
      a = {1'b0, i[0], 3'(i), i[2], i[1], 3'(i), i[0], 3'(i)};
      u_ctrl.issue(4'h0, 2'h0, a);
      `CHK(burst_length_o, (i == 2) ? 4'h4 : (i == 3) ? 4'h8 : 4'h0)
      `CHK(burst_order_o, i[0])
      `CHK(read_latency_o, 3'(i))
      `CHK(read_latency_bad_o, !(i inside {[2:5]}))
      `CHK(vendor_test_select_o, i[1])
      if (i inside {[1:5]}) `CHK(write_recovery_o, 3'(i + 1))
      `CHK(write_recovery_bad_o, !(i inside {[1:5]}))
      `CHK(power_down_exit_speed_o, i[0])
    end
    $display("primary register test done");
    for (int i = 0; i < 5; i++)
    begin
      a = {1'b0, i[2], i[1], i[0], cm[i], i[1], 3'(i), i[0], i[1], i[0]};
      u_ctrl.issue(4'h0, 2'h1, a);
      `CHK(dll_enable_o, !i[0])
      `CHK(driver_strength_select_o, i[1])
      `CHK(termination_o, 2'(i))
      `CHK(termination_bad_o, i[1] & i[0])
      `CHK(added_latency_o, 3'(i))
      `CHK(driver_calibration_o, cm[i])
      `CHK(strobe_single_o, i[0])
      `CHK(read_strobe_o, i[1])
      `CHK(write_mask_en_o, !i[1])
      `CHK(out_disable_o, i[2])
      rd_data_valid_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      `CHK(data_oe_o, !i[2])
      `CHK(comp_strobe_oe_o, !i[2] && !i[0])
      `CHK(comp_strobe_o, !i[0])
      `CHK(read_strobe_oe_o, !i[2] && i[1])
      rd_data_valid_i <= 1'b0;
      if (cm[i] != 3'h0) u_ctrl.issue(4'h0, 2'h1, a & 14'h3C7F);
    end
    $display("extended register test done");
    u_ctrl.issue(4'h0, 2'h2, 14'h1FFF);
    u_ctrl.issue(4'h0, 2'h3, 14'h0000);
    `CHK(added_latency_o, 3'h4)
    `CHK(burst_order_o, 1'b1)
    `CHK(n_rst, 4)
    `CHK(n_ext, 10)
    u_ctrl.issue(4'h0, 2'h0, 14'h0632);
    `CHK(write_recovery_o, 3'h4)
    $display("spare bank test done");
    u_ctrl.issue(4'h0, 2'h1, 14'h0000);
    self_refresh_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    `CHK(dll_enable_o, 1'b0)
    self_refresh_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    `CHK(dll_enable_o, 1'b1)
    $display("self-refresh test done");
    for (int k = 0; k < 5; k++)
    begin
      u_ctrl.issue(4'h0, 2'h1, 14'(k << 3));
      repeat (200) @(posedge ref_clk_i);
      meas(4'h5, n);
      if (k == 0) base = n;
      `CHK(n, base + k)
      meas(4'h4, n);
      `CHK(n, base + k)
    end
    $display("added latency test done");
    print_verdict();
  end
endmodule : dram_mode_register_decode_bench
